// [common/window_watchdog_consts.vh]
`ifndef WINDOW_WATCHDOG_CONSTS_VH
`define WINDOW_WATCHDOG_CONSTS_VH
// clock rate in kHz
`define WD_CLK_KHZ 10000
// mode field codes
`define WD_MODE_OFF 2'h0
`define WD_MODE_WINDOW 2'h1
`define WD_MODE_TIMEOUT 2'h2
// period select codes, longest is the start-up default
`define WD_PER_16MS 2'h0
`define WD_PER_32MS 2'h1
`define WD_PER_64MS 2'h2
`define WD_PER_128MS 2'h3
`define WD_PER_DEFAULT 2'h3
// times in microseconds as printed
`define WD_TRIG_LOW_US 60
`define WD_PERIOD_16_US 16000
`define WD_PERIOD_32_US 32000
`define WD_PERIOD_64_US 64000
`define WD_PERIOD_128_US 128000
`define WD_RST_SHORT_US 700
`define WD_RST_LONG_US 4000
// cycle counts derived from the times (least times round up)
`define WD_TRIG_LOW_CYC ((`WD_TRIG_LOW_US * `WD_CLK_KHZ + 999) / 1000)
`define WD_US_TO_CYC(t) (((t) * `WD_CLK_KHZ) / 1000)
// operating states of the device
`define ST_NORMAL 3'h0
`define ST_STANDBY 3'h1
`define ST_PORT 3'h2
`define ST_GO_TO_SLEEP 3'h3
`define ST_SLEEP 3'h4
`define ST_RESET 3'h5
`define ST_CONFIG 3'h6
`endif

// [verilog/window_watchdog.v]
`include "window_watchdog_consts.vh"
`default_nettype none
// Behaviour
// - mode 01 window, 10 timeout; autonomous bit set gives autonomous behaviour.
// - timeout behaviour restarts on any trigger, resets when period elapses.
// - window behaviour accepts triggers only in second half of period.
// - window behaviour resets on early trigger or overflow.
// - trigger is a low pulse of at least 60 us; shorter ignored.
// - failure enters reset state and pulses the pin low by driving reset_out_oe_n low; the module only raises watchdog_fail, op_state is an input.
// - first trigger after start-up supervised in timeout with longest period.
// - four selectable periods, longest is the start-up default.
// - periods are 16, 32, 64 and 128 ms.
// - autonomous: stop on leaving normal, restart on wake or normal.
// - autonomous: off in standby, port, go-to-sleep while no wake pending.
// - window/timeout run in active states; off in sleep, reset, config.
// - configuration changes only taken in configuration state.
// - software-development: sample trigger at reset-to-standby, high enables.
// - factory condition: configuration state with watchdog off.
// - after programming with watchdog off, standby with watchdog disabled.
// - reset pulse length 0.7 or 4.0 ms.
module window_watchdog
(
    // clock and reset
    input wire clk,
    input wire reset_n,
    // device operating state and wake indication
    input wire [2:0] op_state,
    input wire wake_pending,
    // nonvolatile configuration, with write strobe from programming
    input wire nonvolatile_config_write,
    input wire [1:0] watchdog_mode_select,
    input wire autonomous_select,
    input wire sw_development_enable,
    input wire [1:0] watchdog_period_select,
    input wire reset_length_long,
    // pins
    input wire trigger_input,
    output wire reset_out_n,
    output wire reset_out_oe_n,
    // status
    output wire watchdog_active,
    output reg watchdog_fail
);
    // counts are worked out at full integer width, then cut to the counter width
    localparam [31:0] TRIG_FULL = `WD_TRIG_LOW_CYC;
    localparam [31:0] RST_SHORT_FULL = `WD_US_TO_CYC(`WD_RST_SHORT_US);
    localparam [31:0] RST_LONG_FULL = `WD_US_TO_CYC(`WD_RST_LONG_US);
    localparam [31:0] PER_16_FULL = `WD_US_TO_CYC(`WD_PERIOD_16_US);
    localparam [31:0] PER_32_FULL = `WD_US_TO_CYC(`WD_PERIOD_32_US);
    localparam [31:0] PER_64_FULL = `WD_US_TO_CYC(`WD_PERIOD_64_US);
    localparam [31:0] PER_128_FULL = `WD_US_TO_CYC(`WD_PERIOD_128_US);
    localparam [23:0] TRIG_CYC = TRIG_FULL[23:0];
    localparam [23:0] RST_SHORT_CYC = RST_SHORT_FULL[23:0];
    localparam [23:0] RST_LONG_CYC = RST_LONG_FULL[23:0];

    // period length in cycles for a select code
    function [23:0] period_cyc;
        input [1:0] sel;
        begin
            case (sel)
                `WD_PER_16MS: period_cyc = PER_16_FULL[23:0];
                `WD_PER_32MS: period_cyc = PER_32_FULL[23:0];
                `WD_PER_64MS: period_cyc = PER_64_FULL[23:0];
                default: period_cyc = PER_128_FULL[23:0];
            endcase
        end
    endfunction

    // ==========================================================
    // configuration held from nonvolatile settings
    reg [1:0] mode_q;
    reg auto_q;
    reg sdm_q;
    reg [1:0] per_q;
    reg rst_long_q;
    // factory state: mode off, longest period
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_q <= `WD_MODE_OFF;
            auto_q <= 1'b0;
            sdm_q <= 1'b0;
            per_q <= `WD_PER_DEFAULT;
            rst_long_q <= 1'b0;
        end
        else if (nonvolatile_config_write && op_state == `ST_CONFIG)
        begin
            mode_q <= watchdog_mode_select;
            auto_q <= autonomous_select;
            sdm_q <= sw_development_enable;
            per_q <= watchdog_period_select;
            rst_long_q <= reset_length_long;
        end
    end

    // ==========================================================
    // trigger pin synchroniser and low-pulse filter
    reg [2:0] trig_sync_q;
    reg trig_lvl_q;
    reg [23:0] low_cnt_q;
    reg trig_pulse_q;
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            trig_sync_q <= 3'h7;
            trig_lvl_q <= 1'b1;
            low_cnt_q <= 24'h0;
            trig_pulse_q <= 1'b0;
        end
        else
        begin
            trig_sync_q <= {trig_sync_q[1:0], trigger_input};
            if (trig_sync_q[1] == trig_sync_q[2])
                trig_lvl_q <= trig_sync_q[2];
            trig_pulse_q <= 1'b0;
            if (!trig_lvl_q)
            begin
                if (low_cnt_q < TRIG_CYC)
                    low_cnt_q <= low_cnt_q + 24'h1;
            end
            else
            begin
                // pulse counts on release only when long enough
                if (low_cnt_q >= TRIG_CYC)
                    trig_pulse_q <= 1'b1;
                low_cnt_q <= 24'h0;
            end
        end
    end

    // ==========================================================
    // enable by state, behaviour and software-development strap
    reg [2:0] state_prev_q;
    reg sdm_on_q;
    reg first_q;
    wire run_mode = (mode_q == `WD_MODE_WINDOW) || (mode_q == `WD_MODE_TIMEOUT);
    wire off_state = (op_state == `ST_SLEEP) || (op_state == `ST_RESET) ||
        (op_state == `ST_CONFIG);
    // autonomous runs only in normal or with a wake pending
    wire auto_ok = (op_state == `ST_NORMAL) || wake_pending;
    wire enabled = run_mode && !off_state && (!auto_q || auto_ok) &&
        (!sdm_q || sdm_on_q);
    reg enabled_q;
    assign watchdog_active = enabled;

    // strap sampled on reset-to-standby transition
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_prev_q <= `ST_RESET;
            sdm_on_q <= 1'b0;
            enabled_q <= 1'b0;
        end
        else
        begin
            state_prev_q <= op_state;
            enabled_q <= enabled;
            if (state_prev_q == `ST_RESET && op_state == `ST_STANDBY)
                sdm_on_q <= trig_lvl_q;
        end
    end

    // ==========================================================
    // watchdog timer and supervision
    reg [23:0] timer_q;
    reg [23:0] rst_cnt_q;
    wire [23:0] cur_per = first_q ? period_cyc(`WD_PER_DEFAULT) : period_cyc(per_q);
    wire is_window = !first_q && mode_q == `WD_MODE_WINDOW;
    wire early = is_window && (timer_q < {1'b0, cur_per[23:1]});
    // failure: trigger in the closed half, or the period running out
    wire fail = enabled_q && enabled &&
        ((trig_pulse_q && early) || (timer_q >= cur_per - 24'h1));
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            timer_q <= 24'h0;
            first_q <= 1'b1;
            rst_cnt_q <= 24'h0;
            watchdog_fail <= 1'b0;
        end
        else
        begin
            watchdog_fail <= fail;
            // reset pulse length counts down to zero
            if (rst_cnt_q != 24'h0)
                rst_cnt_q <= rst_cnt_q - 24'h1;
            // a failure restarts supervision under the start-up rule
            if (fail)
            begin
                rst_cnt_q <= rst_long_q ? RST_LONG_CYC : RST_SHORT_CYC;
                timer_q <= 24'h0;
                first_q <= 1'b1;
            end
            else if (!enabled || !enabled_q || op_state == `ST_RESET)
            begin
                timer_q <= 24'h0;
                if (!enabled)
                    first_q <= 1'b1;
            end
            else if (trig_pulse_q)
            begin
                timer_q <= 24'h0;
                first_q <= 1'b0;
            end
            else
                timer_q <= timer_q + 24'h1;
        end
    end

    // reset pin is open drain: driven low while pulse runs
    assign reset_out_n = 1'b0;
    assign reset_out_oe_n = (rst_cnt_q == 24'h0);
endmodule // window_watchdog
`default_nettype wire

// [verif/window_watchdog_asserts.sv]
`include "window_watchdog_consts.vh"
`default_nettype none
// ====
// port checker
module window_watchdog_asserts
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // state
    input wire logic [2:0] op_state,
    // outputs
    input wire logic reset_out_n,
    input wire logic reset_out_oe_n,
    input wire logic watchdog_active,
    input wire logic watchdog_fail
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    fail_drives_pin_a:
        assert property (watchdog_fail |=> !reset_out_oe_n) else $error("pin not driven");
    pin_level_low_a:
        assert property (!reset_out_oe_n |-> !reset_out_n) else $error("pin not low");
    fail_one_cycle_a:
        assert property (watchdog_fail |=> !watchdog_fail) else $error("fail too long");
    pulse_has_cause_a:
        assert property ($fell(reset_out_oe_n) |-> watchdog_fail) else $error("no cause");
    pulse_min_len_a:
        assert property ($fell(reset_out_oe_n) |-> !reset_out_oe_n[*8]) else $error("short");
    off_states_a:
        assert property (op_state >= `ST_SLEEP |-> !watchdog_active) else $error("active");
    fail_when_active_a:
        assert property (watchdog_fail |-> $past(watchdog_active)) else $error("idle fail");
    enable_clears_a:
        assert property ($rose(watchdog_active) |=> !watchdog_fail[*8]) else $error("stale");
endmodule // window_watchdog_asserts
bind window_watchdog window_watchdog_asserts chk (.clk(clk), .reset_n(reset_n),
    .op_state(op_state), .reset_out_n(reset_out_n), .reset_out_oe_n(reset_out_oe_n),
    .watchdog_active(watchdog_active), .watchdog_fail(watchdog_fail));
`default_nettype wire

// [verif/host_mcu.sv]
`default_nettype none
// ====
// host trigger source, pin idles high
module host_mcu
(
    // clock
    input wire logic clk,
    // trigger pin
    output var logic trigger_input
);
    timeunit 1ns;
    timeprecision 1ns;
    initial trigger_input = 1'b1;
    // low pulse of n cycles, changed on falling edges
    task automatic send(input int n);
        @(negedge clk);
        trigger_input = 1'b0;
        repeat (n) @(negedge clk);
        trigger_input = 1'b1;
        // idle gap so that a following pulse is not merged by the pin filter
        repeat (8) @(negedge clk);
    endtask
    // hold the pin at a level, for the strap sampled at reset exit
    task automatic level(input logic v);
        @(negedge clk);
        trigger_input = v;
    endtask
endmodule // host_mcu
`default_nettype wire

// [verif/window_watchdog_tb.sv]
`include "window_watchdog_consts.vh"
`default_nettype none
// ====
// bench top
module window_watchdog_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset_n, wake_pending, nv_wr, auto_sel, sdm, len_long;
    logic [2:0] op_state;
    logic [1:0] mode, per;
    wire trigger_input, reset_out_n, reset_out_oe_n, watchdog_active, watchdog_fail;
    int bad_count = 0, n_compared = 0, low_len;
    int exp_q[$];
    host_mcu host (.clk(clk), .trigger_input(trigger_input));
    window_watchdog uut (.clk(clk), .reset_n(reset_n), .op_state(op_state),
        .wake_pending(wake_pending), .nonvolatile_config_write(nv_wr),
        .watchdog_mode_select(mode), .autonomous_select(auto_sel),
        .sw_development_enable(sdm), .watchdog_period_select(per),
        .reset_length_long(len_long), .trigger_input(trigger_input),
        .reset_out_n(reset_out_n), .reset_out_oe_n(reset_out_oe_n),
        .watchdog_active(watchdog_active), .watchdog_fail(watchdog_fail));
    // clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // measure each reset pulse against the oldest note
    always @(negedge reset_out_oe_n)
    begin
        low_len = 0;
        // count the settled low level once per cycle, between edges
        @(negedge clk);
        check(watchdog_fail, 1'b1);
        check(reset_out_n, 1'b0);
        while (reset_out_oe_n === 1'b0 && low_len < 50000)
        begin
            low_len++;
            @(negedge clk);
        end
        check(low_len, exp_q.size() ? exp_q.pop_front() : -1);
    end
    // hang guard
    initial
    begin
        #8_000_000;
        bad_count++;
        give_verdict();
    end
    // main sequence
    initial
    begin
        {reset_n, wake_pending, nv_wr, auto_sel, sdm, len_long} = 6'h00;
        op_state = `ST_CONFIG;
        mode = `WD_MODE_WINDOW;
        per = `WD_PER_16MS;
        void'($urandom(60));
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        check(watchdog_active, 1'b0);
        nv_wr = 1'b1;
        @(negedge clk);
        op_state = `ST_STANDBY;
        mode = `WD_MODE_OFF;
        @(negedge clk);
        nv_wr = 1'b0;
        check(watchdog_active, 1'b1);
        host.send(`WD_TRIG_LOW_CYC + 20);
        host.send(100 + $urandom_range(400));
        repeat (50) @(negedge clk);
        exp_q.push_back(`WD_US_TO_CYC(`WD_RST_SHORT_US));
        host.send(`WD_TRIG_LOW_CYC + 20);
        repeat (7100) @(negedge clk);
        check(exp_q.size(), 0);
        for (int s = 4; s < 7; s++)
        begin
            op_state = 3'(s);
            @(negedge clk);
            check(watchdog_active, 1'b0);
        end
        // long reset pulse after an early trigger
        mode = `WD_MODE_WINDOW;
        len_long = 1'b1;
        nv_wr = 1'b1;
        @(negedge clk);
        nv_wr = 1'b0;
        op_state = `ST_STANDBY;
        host.send(`WD_TRIG_LOW_CYC + 20);
        exp_q.push_back(`WD_US_TO_CYC(`WD_RST_LONG_US));
        host.send(`WD_TRIG_LOW_CYC + 20);
        repeat (40100) @(negedge clk);
        check(exp_q.size(), 0);
        // strap: pin low, then high, at reset-to-standby
        op_state = `ST_CONFIG;
        mode = `WD_MODE_TIMEOUT;
        sdm = 1'b1;
        nv_wr = 1'b1;
        @(negedge clk);
        nv_wr = 1'b0;
        for (int v = 0; v < 2; v++)
        begin
            op_state = `ST_RESET;
            host.level(v[0]);
            repeat (10) @(negedge clk);
            op_state = `ST_STANDBY;
            @(negedge clk);
            check(watchdog_active, v[0]);
        end
        // autonomous: off in standby without wake, on with wake or in normal
        op_state = `ST_CONFIG;
        {auto_sel, sdm} = 2'b10;
        mode = `WD_MODE_WINDOW;
        nv_wr = 1'b1;
        @(negedge clk);
        nv_wr = 1'b0;
        op_state = `ST_STANDBY;
        @(negedge clk);
        check(watchdog_active, 1'b0);
        wake_pending = 1'b1;
        @(negedge clk);
        check(watchdog_active, 1'b1);
        wake_pending = 1'b0;
        op_state = `ST_NORMAL;
        @(negedge clk);
        check(watchdog_active, 1'b1);
        op_state = `ST_GO_TO_SLEEP;
        @(negedge clk);
        check(watchdog_active, 1'b0);
        // programmed off: standby stays unsupervised even with a wake pending
        op_state = `ST_CONFIG;
        mode = `WD_MODE_OFF;
        nv_wr = 1'b1;
        @(negedge clk);
        nv_wr = 1'b0;
        op_state = `ST_STANDBY;
        wake_pending = 1'b1;
        @(negedge clk);
        check(watchdog_active, 1'b0);
        give_verdict();
    end
endmodule // window_watchdog_tb
`default_nettype wire
